/* File: srpg_cfg.svh */
// Register offsets, reset words, write masks and timing counts.
// Assumes inclusion by the top module only; the package does not include it.
`ifndef SRPG_CFG_SVH
`define SRPG_CFG_SVH

`define SRPG_OFS_CTRL    8'h00
`define SRPG_OFS_PULSE   8'h04
`define SRPG_OFS_PIN     8'h08
`define SRPG_OFS_DELAY   8'h0C
`define SRPG_OFS_STATUS  8'h10

`define SRPG_RST_CTRL    32'h0000_1000
`define SRPG_RST_PULSE   32'h0000_0004
`define SRPG_RST_PIN     32'h0000_0000
`define SRPG_RST_DELAY   32'h0000_1B24

`define SRPG_MASK_CTRL   32'h0000_7F3F
`define SRPG_MASK_PULSE  32'h07FF_000F
`define SRPG_MASK_PIN    32'h0000_0FF1
`define SRPG_MASK_DELAY  32'h3F3F_3F3F

`define SRPG_SRC_PULSE   3'h2
`define SRPG_PDIV_BASE   13'h0004
`define SRPG_INCL_LO     12'h004
`define SRPG_INCL_HI     12'h006
`define SRPG_OSC_DIV     12'h008

`endif

/* File: srpg_far_end.sv */
// Far-side model: request driver and a converter counting pulses.
// Assumes one clock hclk and a single-ended request pin.
module srpg_far_end (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        req_level,
    input  wire logic        clear,
    input  wire logic        rf_output_two,
    output logic             pulse_request_in,
    output logic [15:0]      pulse_count,
    output logic [15:0]      last_period
);
    logic        prev;
    logic [15:0] since;

    // Single-ended drive only; held high to keep a stream going
    assign pulse_request_in = req_level;

    // First period after clear is junk: since is not cleared and spans back to the last rise before it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev        <= 1'b0;
            since       <= 16'h0000;
            pulse_count <= 16'h0000;
            last_period <= 16'h0000;
        end else begin
            prev  <= rf_output_two;
            since <= since + 16'h0001;
            if (clear) begin
                pulse_count <= 16'h0000;
                last_period <= 16'h0000;
            end else if (rf_output_two && !prev) begin
                pulse_count <= pulse_count + 16'h0001;
                last_period <= since + 16'h0001;
                since       <= 16'h0000;
            end
        end
    end
endmodule : srpg_far_end

/* File: srpg_pkg.sv */
// Types shared by the pulse generator and its register file.
// Assumes srpg_cfg.svh is on the include path.
package srpg_pkg;

    typedef struct packed {
        logic [16:0] rsv_hi;
        logic [2:0]  interp_prediv;
        logic        fixed_feedback_divide;
        logic [2:0]  out2_source_sel;
        logic [1:0]  rsv_lo;
        logic        pulse_style;
        logic        role_select;
        logic        pulse_out_enable;
        logic        phase_sync_mode;
        logic        soft_reset;
        logic        powerdown;
    } srpg_ctrl_s;

    typedef struct packed {
        logic [4:0]  rsv_hi;
        logic [10:0] pulse_divider;
        logic [11:0] rsv_lo;
        logic [3:0]  burst_length;
    } srpg_pulse_s;

    typedef struct packed {
        logic [19:0] rsv_hi;
        logic [3:0]  input_hysteresis;
        logic [3:0]  input_bias_level;
        logic [2:0]  rsv_lo;
        logic        input_format_sel;
    } srpg_pin_s;

    typedef struct packed {
        logic [1:0]  rsv;
        logic [5:0]  word;
    } srpg_dword_s;

    typedef srpg_dword_s [3:0] srpg_delay_t;

    typedef enum logic {
        SRPG_MASTER,
        SRPG_REPEATER
    } srpg_role_e;

    typedef enum logic [1:0] {
        GEN_IDLE,
        GEN_CONT,
        GEN_BURST
    } srpg_gen_e;

endpackage : srpg_pkg

/* File: srpg_sync.sv */
// Two-flop synchroniser for the two pin inputs.
// Assumes asynchronous pins and one clock hclk.
module srpg_sync (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [1:0] pin,
    output logic      [1:0] pin_s
);
    logic [1:0] meta;
    logic [1:0] next_meta;

    always_comb begin
        next_meta = pin;
    end

    // First stage feeds the second only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta  <= 2'h0;
            pin_s <= 2'h0;
        end else begin
            meta  <= next_meta;
            pin_s <= meta;
        end
    end
endmodule : srpg_sync

/* File: srpg_tick.sv */
// Programmable divider giving a one-cycle enable every period cycles.
// Assumes period is at least one while run is high.
module srpg_tick (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        run,
    input  wire logic [11:0] period,
    output logic             tick
);
    logic [11:0] cnt;
    logic [11:0] next_cnt;
    logic        next_tick;

    always_comb begin
        next_cnt  = cnt + 12'h001;
        next_tick = 1'b0;
        if (!run) begin
            next_cnt = 12'h000;
        end else if (cnt >= period - 12'h001) begin
            next_cnt  = 12'h000;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt  <= 12'h000;
            tick <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule : srpg_tick

/* File: srpg_top.sv */
// Pulse generator for the second RF output, with AHB-Lite registers.
// Assumes hclk stands for the VCO/first-output clock; pins are async.
//
// How it works
// - Pre-divider codes 1, 2, 4 divide by that; others invalid.
// - Role bit: 0 master generates pulses, 1 repeater; resets to 0.
// - Style bit: 0 continuous, 1 counted burst; resets to 0.
// - Burst length 0 to 15, reset 4; zero legal, gives nothing.
// - Divider code n divides by 4 plus 2n; resets to 0.
// - Repeater outputs request, reclocked to interpolator then output clock.
// - Master reclocks request to oscillator, interpolator, then output clock.
// - Pulse rate is VCO over twice fixed, pre and pulse divides.
// - Continuous style pulses while request stays high.
// - Burst style emits burst length pulses per request rising edge seen while idle; edges during a burst are ignored.
// - Bias level and hysteresis adjustable for differential input.
// - Four delay words set output two delay versus output one.
// - Soft reset with powerdown clear resets registers; pin or bit powers down.
//
// Local design decisions: the address map and the AHB-Lite register port.
`include "srpg_cfg.svh"

module srpg_top (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic      [31:0]        hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire logic               pulse_request_in,
    input  wire logic               chip_enable,
    output logic                    rf_output_two,
    output logic                    input_format_sel,
    output logic      [3:0]         input_bias_level,
    output logic      [3:0]         input_hysteresis,
    output logic      [23:0]        delay_ctrl_word
);
    import srpg_pkg::*;

    srpg_ctrl_s  ctrl;
    srpg_pulse_s pulse;
    srpg_pin_s   pin;
    srpg_delay_t delay;
    srpg_ctrl_s  next_ctrl;
    srpg_pulse_s next_pulse;
    srpg_pin_s   next_pin;
    srpg_delay_t next_delay;

    logic        dph_wr;
    logic [7:0]  dph_addr;
    logic        next_dph_wr;
    logic [7:0]  next_dph_addr;
    logic [31:0] next_hrdata;
    logic        take;

    logic [1:0]  pins_s;
    logic        req_s;
    logic        pd;
    logic        prediv_bad;
    logic [11:0] incl;
    logic [11:0] interp_period;
    logic        interp_tick;
    logic        osc_tick;

    logic        osc_q;
    logic        interp_q;
    logic        out_q;
    logic        out_prev;
    logic        next_osc_q;
    logic        next_interp_q;
    logic        next_out_q;
    logic        next_out_prev;
    logic        rise;

    srpg_gen_e   state;
    srpg_gen_e   next_state;
    logic        level;
    logic        next_level;
    logic [12:0] hcnt;
    logic [12:0] next_hcnt;
    logic [3:0]  remain;
    logic [3:0]  next_remain;
    logic [12:0] half;
    logic        gen_ok;
    logic        out_ok;
    logic        next_rf2;
    logic [31:0] status;

    // Pins are asynchronous: both pass two flops first
    srpg_sync u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     ({chip_enable, pulse_request_in}),
        .pin_s   (pins_s)
    );

    assign req_s = pins_s[0];
    assign pd    = ctrl.powerdown | ~pins_s[1];

    // Interpolator enable: fixed divide times pre-divider
    always_comb begin
        incl = ctrl.fixed_feedback_divide ? `SRPG_INCL_HI : `SRPG_INCL_LO;
        prediv_bad    = 1'b0;
        interp_period = incl;
        case (ctrl.interp_prediv)
            3'h1: interp_period = incl;
            3'h2: interp_period = incl << 1;
            3'h4: interp_period = incl << 2;
            default: prediv_bad = 1'b1;
        endcase
    end

    srpg_tick u_interp (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (~pd & ~prediv_bad),
        .period  (interp_period),
        .tick    (interp_tick)
    );

    srpg_tick u_osc (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (~pd),
        .period  (`SRPG_OSC_DIV),
        .tick    (osc_tick)
    );

    // Bus address phase; zero wait states, always OKAY
    assign take = hsel & hready & htrans[1];

    always_comb begin
        next_ctrl     = ctrl;
        next_pulse    = pulse;
        next_pin      = pin;
        next_delay    = delay;
        next_dph_wr   = take & hwrite;
        next_dph_addr = haddr[7:0];
        if (dph_wr) begin
            case (dph_addr)
                `SRPG_OFS_CTRL:
                    next_ctrl = srpg_ctrl_s'(hwdata & `SRPG_MASK_CTRL);
                `SRPG_OFS_PULSE:
                    next_pulse = srpg_pulse_s'(hwdata & `SRPG_MASK_PULSE);
                `SRPG_OFS_PIN:
                    next_pin = srpg_pin_s'(hwdata & `SRPG_MASK_PIN);
                `SRPG_OFS_DELAY:
                    next_delay = srpg_delay_t'(hwdata & `SRPG_MASK_DELAY);
                default: next_ctrl = ctrl;
            endcase
        end
        // Reset bit clears itself along with the pulse, pin and delay registers
        if (ctrl.soft_reset && !ctrl.powerdown) begin
            next_ctrl  = srpg_ctrl_s'(`SRPG_RST_CTRL);
            next_pulse = srpg_pulse_s'(`SRPG_RST_PULSE);
            next_pin   = srpg_pin_s'(`SRPG_RST_PIN);
            next_delay = srpg_delay_t'(`SRPG_RST_DELAY);
        end
    end

    assign status = {22'h000000, pd, prediv_bad, remain, 2'h0, out_q,
                     state != GEN_IDLE};

    // Read mux sees next values so a read right after a write is fresh
    always_comb begin
        next_hrdata = 32'h0000_0000;
        if (take && !hwrite) begin
            case (haddr[7:0])
                `SRPG_OFS_CTRL:   next_hrdata = next_ctrl;
                `SRPG_OFS_PULSE:  next_hrdata = next_pulse;
                `SRPG_OFS_PIN:    next_hrdata = next_pin;
                `SRPG_OFS_DELAY:  next_hrdata = next_delay;
                `SRPG_OFS_STATUS: next_hrdata = status;
                default:          next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl      <= srpg_ctrl_s'(`SRPG_RST_CTRL);
            pulse     <= srpg_pulse_s'(`SRPG_RST_PULSE);
            pin       <= srpg_pin_s'(`SRPG_RST_PIN);
            delay     <= srpg_delay_t'(`SRPG_RST_DELAY);
            dph_wr    <= 1'b0;
            dph_addr  <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            ctrl      <= next_ctrl;
            pulse     <= next_pulse;
            pin       <= next_pin;
            delay     <= next_delay;
            dph_wr    <= next_dph_wr;
            dph_addr  <= next_dph_addr;
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign input_format_sel = pin.input_format_sel;
    assign input_bias_level = pin.input_bias_level;
    assign input_hysteresis = pin.input_hysteresis;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_dly
            assign delay_ctrl_word[6*gi +: 6] = delay[gi].word;
        end
    endgenerate

    // Request reclocking chain; output clock is hclk itself
    always_comb begin
        next_osc_q    = osc_tick ? req_s : osc_q;
        next_interp_q = interp_q;
        if (interp_tick) begin
            next_interp_q = ctrl.role_select ? req_s : osc_q;
        end
        next_out_q    = interp_q;
        next_out_prev = out_q;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_q    <= 1'b0;
            interp_q <= 1'b0;
            out_q    <= 1'b0;
            out_prev <= 1'b0;
        end else begin
            osc_q    <= next_osc_q;
            interp_q <= next_interp_q;
            out_q    <= next_out_q;
            out_prev <= next_out_prev;
        end
    end

    assign rise   = out_q & ~out_prev;
    assign half   = `SRPG_PDIV_BASE + {1'b0, pulse.pulse_divider, 1'b0};
    assign gen_ok = ~pd & (ctrl.role_select == SRPG_MASTER) & ~prediv_bad;
    assign out_ok = ctrl.pulse_out_enable & ctrl.phase_sync_mode
                  & (ctrl.out2_source_sel == `SRPG_SRC_PULSE) & ~pd;

    // Generator: level toggles every half interpolator ticks
    always_comb begin
        next_state  = state;
        next_level  = level;
        next_hcnt   = hcnt;
        next_remain = remain;
        case (state)
            GEN_IDLE: begin
                next_level = 1'b0;
                next_hcnt  = 13'h0000;
                if (!ctrl.pulse_style && out_q) begin
                    next_state = GEN_CONT;
                end else if (ctrl.pulse_style && rise
                             && pulse.burst_length != 4'h0) begin
                    next_state  = GEN_BURST;
                    next_remain = pulse.burst_length;
                end
            end
            GEN_CONT, GEN_BURST: begin
                // Stop only while low so no runt pulse leaves
                if (state == GEN_CONT && !level
                    && (!out_q || ctrl.pulse_style)) begin
                    next_state = GEN_IDLE;
                end else if (interp_tick) begin
                    if (hcnt == half - 13'h0001) begin
                        next_hcnt  = 13'h0000;
                        next_level = ~level;
                        if (state == GEN_BURST && level) begin
                            next_remain = remain - 4'h1;
                            if (remain == 4'h1) begin
                                next_state = GEN_IDLE;
                            end
                        end
                    end else begin
                        next_hcnt = hcnt + 13'h0001;
                    end
                end
            end
            default: next_state = GEN_IDLE;
        endcase
        if (!gen_ok) begin
            next_state  = GEN_IDLE;
            next_level  = 1'b0;
            next_hcnt   = 13'h0000;
            next_remain = 4'h0;
        end
    end

    always_comb begin
        next_rf2 = out_ok & (ctrl.role_select ? out_q : level);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state         <= GEN_IDLE;
            level         <= 1'b0;
            hcnt          <= 13'h0000;
            remain        <= 4'h0;
            rf_output_two <= 1'b0;
        end else begin
            state         <= next_state;
            level         <= next_level;
            hcnt          <= next_hcnt;
            remain        <= next_remain;
            rf_output_two <= next_rf2;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_prediv_bad;
        prediv_bad [*2] |-> !interp_tick;
    endproperty
    a_prediv_bad: assert property (p_prediv_bad)
        else $error("interpolator tick with invalid pre-divider");

    property p_repeater_idle;
        ctrl.role_select |=> state == GEN_IDLE && !level;
    endproperty
    a_repeater_idle: assert property (p_repeater_idle)
        else $error("generator active in repeater role");

    property p_soft_reset;
        ctrl.soft_reset && !ctrl.powerdown |=> pulse.burst_length == 4'h4
            && pulse.pulse_divider == 11'h000 && !ctrl.role_select;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset did not restore defaults");

    property p_half_period;
        state != GEN_IDLE && gen_ok && !(interp_tick
            && hcnt == half - 13'h0001) |=> level == $past(level);
    endproperty
    a_half_period: assert property (p_half_period)
        else $error("level changed before half period");

    property p_repeat_copy;
        out_ok && ctrl.role_select |=> rf_output_two == $past(out_q);
    endproperty
    a_repeat_copy: assert property (p_repeat_copy)
        else $error("repeater output is not the reclocked request");

    property p_interp_stage;
        !interp_tick |=> $stable(interp_q);
    endproperty
    a_interp_stage: assert property (p_interp_stage)
        else $error("request changed off interpolator tick");

    property p_cont_stop;
        state == GEN_CONT && !out_q && !level |=> state == GEN_IDLE;
    endproperty
    a_cont_stop: assert property (p_cont_stop)
        else $error("continuous stream outlived request");

    property p_burst_load;
        state == GEN_IDLE && gen_ok && ctrl.pulse_style && rise
            && pulse.burst_length != 4'h0
            |=> state == GEN_BURST && remain == $past(pulse.burst_length);
    endproperty
    a_burst_load: assert property (p_burst_load)
        else $error("burst not loaded on request edge");

    property p_no_retrigger;
        state == GEN_BURST && rise |=> remain <= $past(remain);
    endproperty
    a_no_retrigger: assert property (p_no_retrigger)
        else $error("burst extended by new request edge");

    property p_powerdown;
        pd |=> !rf_output_two;
    endproperty
    a_powerdown: assert property (p_powerdown)
        else $error("output active in powerdown");

    property p_cov_burst;
        state == GEN_BURST ##1 state == GEN_IDLE;
    endproperty
    c_burst: cover property (p_cov_burst);

    property p_cov_cont;
        state == GEN_CONT && rf_output_two;
    endproperty
    c_cont: cover property (p_cov_cont);

    property p_cov_repeat;
        ctrl.role_select && rf_output_two;
    endproperty
    c_repeat: cover property (p_cov_repeat);
endmodule : srpg_top

/* File: test_pulse_style_generator.sv */
// Self-checking bench for the pulse generator and its registers.
// Assumes srpg_top and srpg_far_end are compiled before this file.
module test_pulse_style_generator;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        pulse_request_in;
    logic        chip_enable;
    logic        rf_output_two;
    logic        fmt;
    logic [3:0]  bias;
    logic [3:0]  hyst;
    logic [23:0] dly;
    logic        req_level;
    logic        clear;
    logic [15:0] pulse_count;
    logic [15:0] last_period;
    logic        rd_pend = 1'b0;
    logic        lnk_req;
    logic        lnk_sel;
    logic [31:0] exp_q[$];
    int          n_errors = 0;
    int          samples_checked = 0;
    // Enable and source move together; phase sync dropped alone
    logic [31:0] t_ctrl [9] = '{32'h120C, 32'h220C, 32'h420C, 32'h2A0C,
                                32'h320C, 32'h1004, 32'h1208, 32'h120D,
                                32'h120C};
    logic [31:0] t_pulse [9] = '{0, 0, 0, 32'h0001_0000, 0, 0, 0, 0, 0};
    logic        t_ce [9] = '{1, 1, 1, 1, 1, 1, 1, 1, 0};
    logic [15:0] t_exp [9] = '{32, 64, 128, 144, 0, 0, 0, 0, 0};

    initial hclk = 1'b0;
    always #2 hclk = ~hclk;

    srpg_top srpg_top_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pulse_request_in(pulse_request_in),
        .chip_enable(chip_enable), .rf_output_two(rf_output_two),
        .input_format_sel(fmt), .input_bias_level(bias),
        .input_hysteresis(hyst), .delay_ctrl_word(dly)
    );

    srpg_far_end srpg_far_end_inst (
        .hclk(hclk), .hresetn(hresetn), .req_level(req_level),
        .clear(clear), .rf_output_two(rf_output_two),
        .pulse_request_in(pulse_request_in), .pulse_count(pulse_count),
        .last_period(last_period)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] e);
        samples_checked++;
        if (seen !== e) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, seen, e);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask : idle

    task automatic ahb_cycle(input logic [7:0] a, input logic w,
                             input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0000_0000;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : ahb_cycle

    task automatic ahb_read(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        ahb_cycle(a, 1'b0, 32'h0000_0000);
    endtask : ahb_read

    task automatic link_check(input logic sel, input logic [15:0] e);
        exp_q.push_back({16'h0000, e});
        lnk_sel <= sel;
        lnk_req <= 1'b1;
        @(posedge hclk);
        lnk_req <= 1'b0;
    endtask : link_check

    task automatic pulse_req(input int n);
        req_level <= 1'b1;
        idle(10);
        req_level <= 1'b0;
        idle(n);
    endtask : pulse_req

    task automatic clear_far();
        clear <= 1'b1;
        @(posedge hclk);
        clear <= 1'b0;
    endtask : clear_far

    task automatic wait_rf(input logic v);
        for (int k = 0; k < 100 && rf_output_two !== v; k++) @(posedge hclk);
        check({31'h0, rf_output_two}, {31'h0, v});
    endtask : wait_rf

    // Results come from the bus data phase or from a link sample strobe
    always @(posedge hclk) begin
        if (rd_pend && hreadyout === 1'b1) begin
            check(hrdata, exp_q.pop_front());
            check({31'h0, hresp}, 32'h0000_0000);
        end
        if (lnk_req === 1'b1) begin
            check({16'h0, lnk_sel ? last_period : pulse_count},
                  exp_q.pop_front());
        end
        rd_pend = hsel && htrans[1] && !hwrite && hreadyout;
    end

    initial begin
        repeat (40000) @(posedge hclk);
        n_errors++;
        finish_test();
    end

    initial begin
        logic [31:0] r;
        logic [5:0]  w;
        logic [31:0] dw;
        hresetn     = 1'b0;
        hsel        = 1'b0;
        haddr       = 32'h0;
        htrans      = 2'h0;
        hwrite      = 1'b0;
        hwdata      = 32'h0;
        req_level   = 1'b0;
        clear       = 1'b0;
        chip_enable = 1'b1;
        lnk_req     = 1'b0;
        lnk_sel     = 1'b0;
        void'($urandom(97784));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb_read(8'h00, 32'h0000_1000);
        ahb_read(8'h04, 32'h0000_0004);
        ahb_read(8'h08, 32'h0000_0000);
        ahb_read(8'h0C, 32'h0000_1B24);
        ahb_read(8'h40, 32'h0000_0000);
        check({8'h00, dly}, 32'h0000_06E4);
        $display("test reset_values done");
        r = $urandom;
        ahb_write_read: begin
            // Differential format only while in repeater role
            ahb_cycle(8'h00, 1'b1, 32'h0000_1010);
            ahb_cycle(8'h08, 1'b1, r);
            ahb_read(8'h08, r & 32'h0000_0FF1);
            check({23'h0, fmt, bias, hyst}, {23'h0, r[0], r[7:4], r[11:8]});
            ahb_cycle(8'h08, 1'b1, 32'h0000_0000);
            w  = 6'($urandom_range(63));
            // Words kept summing to 63 as software must
            dw = {16'h0000, 2'b00, 6'd63 - w, 2'b00, w};
            ahb_cycle(8'h0C, 1'b1, dw);
            ahb_read(8'h0C, dw);
            check({8'h00, dly}, {20'h00000, 6'd63 - w, w});
            for (int i = 0; i < 2; i++) begin
                r = (i == 0) ? $urandom : 32'hFFFF_FFFF;
                ahb_cycle(8'h04, 1'b1, r);
                ahb_read(8'h04, r & 32'h07FF_000F);
            end
        end
        $display("test register_fields done");
        ahb_cycle(8'h04, 1'b1, 32'h0000_0003);
        ahb_cycle(8'h00, 1'b1, 32'h0000_122C);
        ahb_read(8'h00, 32'h0000_122C);
        clear_far();
        pulse_req(30);
        // Second rise lands inside the running burst
        pulse_req(200);
        link_check(1'b0, 16'd3);
        pulse_req(200);
        link_check(1'b0, 16'd6);
        ahb_cycle(8'h04, 1'b1, 32'h0000_0000);
        clear_far();
        pulse_req(200);
        link_check(1'b0, 16'd0);
        $display("test burst done");
        for (int i = 0; i < 9; i++) begin
            ahb_cycle(8'h04, 1'b1, t_pulse[i]);
            ahb_cycle(8'h00, 1'b1, t_ctrl[i]);
            chip_enable <= t_ce[i];
            clear_far();
            req_level <= 1'b1;
            idle(600);
            link_check(t_exp[i] != 16'h0, t_exp[i]);
            req_level <= 1'b0;
            idle(200);
            clear_far();
            idle(300);
            link_check(1'b0, 16'd0);
            chip_enable <= 1'b1;
        end
        $display("test stream_and_refusals done");
        ahb_cycle(8'h00, 1'b1, 32'h0000_121C);
        req_level <= 1'b1;
        wait_rf(1'b1);
        req_level <= 1'b0;
        wait_rf(1'b0);
        $display("test repeater done");
        ahb_cycle(8'h00, 1'b1, 32'h0000_0002);
        idle(2);
        ahb_read(8'h00, 32'h0000_1000);
        ahb_read(8'h04, 32'h0000_0004);
        ahb_read(8'h0C, 32'h0000_1B24);
        $display("test soft_reset done");
        idle(2);
        finish_test();
    end
endmodule : test_pulse_style_generator
